// ===== core/schp_port.v
`timescale 1ns/1ns
`default_nettype none
`include "schp_map.vh"
module schp_port #(
    parameter [4:0] DEV_ID = 5'h15  // arbitrary identity value
) (
    // clock and reset
    input  wire       clk,
    input  wire       reset,
    // shared bus
    input  wire [7:0] shared_addr_data_lines_in,
    output reg  [7:0] shared_addr_data_lines_out,
    output reg        shared_addr_data_lines_oe,
    input  wire       chip_select_n,
    input  wire       read_strobe_n,
    input  wire       write_strobe_n,
    output reg        bus_acknowledge_n,
    // interrupt chain
    input  wire       ack_chain_in_n,
    output reg        ack_chain_out_n,
    output reg        irq_request_n,
    // modem pins
    input  wire       data_set_ready_n,
    input  wire       carrier_detect_n,
    input  wire       ring_n,
    // receiver engine
    input  wire       rx_load,
    input  wire [7:0] rx_char,
    input  wire       rx_stop_bit,
    input  wire       rx_parity_bad,
    // transmitter engine
    input  wire       tx_move,
    output reg  [7:0] tx_holding_reg,
    output reg  [7:0] control_one_out,
    output reg  [7:0] control_two_out,
    output reg  [7:0] sync_char_out,
    output reg  [7:0] escape_char_out
);
    // ************************************************************
    // synchronisers and edges
    // ************************************************************
    wire [6:0] pins_s;
    wire [6:0] fall;
    wire [6:0] rise;
    wire [6:0] chg;
    reg  [7:0] bus_in_ff;
    reg  [7:0] bus_meta_ff;
    schp_sync2 #(.W(7)) u_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in ({chip_select_n, read_strobe_n, write_strobe_n, ack_chain_in_n,
                    data_set_ready_n, carrier_detect_n, ring_n}),
        .sync_out (pins_s)
    );
    schp_edge #(.W(7)) u_edge (
        .clk      (clk),
        .reset    (reset),
        .level_in (pins_s),
        .fall     (fall),
        .rise     (rise),
        .change   (chg)
    );
    always @(posedge clk) begin
        if (reset) begin
            bus_meta_ff <= 8'h00;
            bus_in_ff   <= 8'h00;
        end else begin
            bus_meta_ff <= shared_addr_data_lines_in;
            bus_in_ff   <= bus_meta_ff;
        end
    end
    wire cs_n  = pins_s[6];
    wire re_n  = pins_s[5];
    wire aki_n = pins_s[3];
    wire cs_fall = fall[6];
    wire re_fall = fall[5];
    wire we_fall = fall[4];
    wire dsr_chg = chg[2];
    wire cd_chg  = chg[1];
    wire ring_fall = fall[0];

    // ************************************************************
    // registers
    // ************************************************************
    reg       sel_ff;
    reg       ack_cyc_ff;
    reg       replying_ff;
    reg [2:0] reg_sel_ff;
    reg       esc_ptr_ff;
    reg [7:0] rx_hold_ff;
    reg       change_ff;
    reg       frame_ff;
    reg       err3_ff;
    reg       over_ff;
    reg       rdy_ff;
    reg       empty_ff;
    reg       hold_vacant_ff;
    reg       esc_prev_ff;
    reg       irq_pend_ff;
    reg       irq_empty_ff;
    reg       tx_en_prev_ff;
    reg       modem_irq;
    reg       rx_irq;
    reg       empty_irq;
    wire      rx_en   = control_one_out[`SCHP_C1_RX_EN];
    wire      tx_en   = control_one_out[`SCHP_C1_TX_EN];
    wire      dtr     = control_one_out[`SCHP_C1_TERM_RDY];
    wire      sync_md = control_two_out[`SCHP_C2_SYNC_MODE];
    wire      esc_on  = control_one_out[`SCHP_C1_ESC_STRIP];
    wire [7:0] status = {change_ff, ~pins_s[2], ~pins_s[1],
                         frame_ff, err3_ff, over_ff, rdy_ff, empty_ff};
    wire      rd_status = sel_ff & ~ack_cyc_ff & re_fall & (reg_sel_ff == `SCHP_SEL_STATUS);
    wire      rd_rxhold = sel_ff & ~ack_cyc_ff & re_fall & (reg_sel_ff == `SCHP_SEL_RXHOLD);
    wire      wr_any    = sel_ff & ~ack_cyc_ff & we_fall;
    wire      wr_tx     = wr_any & (reg_sel_ff == `SCHP_SEL_RXHOLD);
    wire      id_match  = (bus_in_ff[7:3] == DEV_ID);
    // bit 0 only marks the cycle kind, selects decode bits 2-1
    wire [2:0] addr_sel = {bus_in_ff[2:1], 1'b0};
    wire      irq_taken = replying_ff & re_fall;
    wire      aki_hold  = ack_cyc_ff & ~cs_n & ~aki_n & ~replying_ff & ack_chain_out_n;

    // ************************************************************
    // interrupt sources
    // ************************************************************
    always @* begin
        modem_irq = ((dsr_chg | cd_chg) & dtr) | (ring_fall & ~dtr);
        rx_irq    = rx_load & rx_en;
        empty_irq = (tx_move & tx_en) | (tx_en & ~tx_en_prev_ff & hold_vacant_ff);
    end

    // ************************************************************
    // bus cycle, registers, status
    // ************************************************************
    always @(posedge clk) begin
        if (reset) begin
            sel_ff            <= 1'b0;
            ack_cyc_ff        <= 1'b0;
            replying_ff       <= 1'b0;
            reg_sel_ff        <= 3'h0;
            esc_ptr_ff        <= 1'b0;
            control_one_out   <= `SCHP_CTRL_RST;
            control_two_out   <= `SCHP_CTRL_RST;
            sync_char_out     <= `SCHP_CHAR_RST;
            escape_char_out   <= `SCHP_CHAR_RST;
            tx_holding_reg    <= `SCHP_CHAR_RST;
            bus_acknowledge_n <= 1'b1;
            ack_chain_out_n   <= 1'b1;
            shared_addr_data_lines_out <= 8'h00;
            shared_addr_data_lines_oe  <= 1'b0;
        end else begin
            // address phase on chip select fall
            if (cs_fall) begin
                reg_sel_ff <= addr_sel;
                if (!bus_in_ff[0]) begin
                    ack_cyc_ff <= 1'b1;
                end else if (id_match) begin
                    sel_ff            <= 1'b1;
                    bus_acknowledge_n <= 1'b0;
                    if (addr_sel != `SCHP_SEL_CHARS)
                        esc_ptr_ff <= 1'b0;
                end
            end
            // interrupt acknowledge cycle, decided once per cycle
            if (aki_hold) begin
                if (irq_pend_ff) begin
                    replying_ff       <= 1'b1;
                    bus_acknowledge_n <= 1'b0;
                end else begin
                    ack_chain_out_n <= 1'b0;
                end
            end
            if (replying_ff & re_fall) begin
                shared_addr_data_lines_out <= {DEV_ID, ~irq_empty_ff, 2'b00};
                shared_addr_data_lines_oe  <= 1'b1;
            end
            if (ack_cyc_ff & cs_n & re_n & aki_n) begin
                ack_cyc_ff        <= 1'b0;
                replying_ff       <= 1'b0;
                ack_chain_out_n   <= 1'b1;
                bus_acknowledge_n <= 1'b1;
            end
            // register read
            if (sel_ff & ~ack_cyc_ff & re_fall) begin
                shared_addr_data_lines_oe <= 1'b1;
                case (reg_sel_ff)
                    `SCHP_SEL_CTRL1:  shared_addr_data_lines_out <= control_one_out;
                    `SCHP_SEL_CTRL2:  shared_addr_data_lines_out <= control_two_out;
                    `SCHP_SEL_STATUS: shared_addr_data_lines_out <= status;
                    `SCHP_SEL_RXHOLD: shared_addr_data_lines_out <= rx_hold_ff;
                    default:          shared_addr_data_lines_out <= 8'h00;
                endcase
            end
            if (rise[5])
                shared_addr_data_lines_oe <= 1'b0;
            if (sel_ff & cs_n & re_n) begin
                sel_ff            <= 1'b0;
                bus_acknowledge_n <= 1'b1;
            end
            // register write
            if (wr_any) begin
                case (reg_sel_ff)
                    `SCHP_SEL_CTRL1:  control_one_out <= bus_in_ff;
                    `SCHP_SEL_CTRL2:  control_two_out <= bus_in_ff;
                    `SCHP_SEL_CHARS: begin
                        if (esc_ptr_ff)
                            escape_char_out <= bus_in_ff;
                        else
                            sync_char_out <= bus_in_ff;
                        esc_ptr_ff <= ~esc_ptr_ff;
                    end
                    `SCHP_SEL_RXHOLD: tx_holding_reg <= bus_in_ff;
                    default: ;
                endcase
            end
        end
    end

    // ************************************************************
    // status flags and receive holding
    // ************************************************************
    always @(posedge clk) begin
        if (reset) begin
            rx_hold_ff  <= 8'h00;
            change_ff   <= 1'b0;
            frame_ff    <= 1'b0;
            err3_ff     <= 1'b0;
            over_ff     <= 1'b0;
            rdy_ff      <= 1'b0;
            esc_prev_ff <= 1'b0;
        end else begin
            // status bit 7, set wins over read clear
            if (modem_irq)
                change_ff <= 1'b1;
            else if (rd_status)
                change_ff <= 1'b0;
            // receiver status
            if (!rx_en) begin
                frame_ff    <= 1'b0;
                err3_ff     <= 1'b0;
                over_ff     <= 1'b0;
                rdy_ff      <= 1'b0;
                esc_prev_ff <= 1'b0;
            end else if (rx_load) begin
                rx_hold_ff <= rx_char;
                rdy_ff     <= 1'b1;
                over_ff    <= rdy_ff & ~rd_rxhold;
                if (!sync_md)
                    frame_ff <= ~rx_stop_bit;
                else if (!(control_two_out[`SCHP_C2_SYNC_STRIP] && frame_ff))
                    frame_ff <= (rx_char == sync_char_out);
                else
                    frame_ff <= 1'b0;
                if (esc_on) begin
                    err3_ff     <= esc_prev_ff;
                    esc_prev_ff <= (rx_char == escape_char_out);
                end else begin
                    err3_ff <= control_one_out[`SCHP_C1_RX_PAR] & rx_parity_bad;
                end
            end else begin
                if (rd_rxhold)
                    rdy_ff <= 1'b0;
                if (rd_status & esc_on)
                    err3_ff <= 1'b0;
            end
        end
    end

    // ************************************************************
    // transmit holding empty
    // ************************************************************
    always @(posedge clk) begin
        if (reset) begin
            tx_en_prev_ff  <= 1'b0;
            hold_vacant_ff <= 1'b1;
            empty_ff       <= 1'b0;
        end else begin
            tx_en_prev_ff <= tx_en;
            // vacancy kept while the transmitter is off
            if (tx_move)
                hold_vacant_ff <= 1'b1;
            else if (wr_tx)
                hold_vacant_ff <= 1'b0;
            if (!tx_en)
                empty_ff <= 1'b0;
            else if (tx_move)
                empty_ff <= 1'b1;
            else if (wr_tx)
                empty_ff <= 1'b0;
            else if (!tx_en_prev_ff)
                empty_ff <= hold_vacant_ff;
        end
    end

    // ************************************************************
    // interrupt request, held until acknowledged
    // ************************************************************
    always @(posedge clk) begin
        if (reset) begin
            irq_pend_ff   <= 1'b0;
            irq_empty_ff  <= 1'b0;
            irq_request_n <= 1'b1;
        end else begin
            if (irq_taken) begin
                irq_pend_ff   <= 1'b0;
                irq_empty_ff  <= 1'b0;
                irq_request_n <= 1'b1;
            end
            if (modem_irq | rx_irq | empty_irq) begin
                irq_pend_ff   <= 1'b1;
                irq_request_n <= 1'b0;
                if (empty_irq & ~modem_irq & ~rx_irq & (~irq_pend_ff | irq_taken))
                    irq_empty_ff <= 1'b1;
                else if (modem_irq | rx_irq)
                    irq_empty_ff <= 1'b0;
            end
        end
    end
endmodule // schp_port
`default_nettype wire

// ===== core/schp_map.vh
`ifndef SCHP_MAP_VH
`define SCHP_MAP_VH
// register selects, address bits 2-1 with bit 0 taken as zero
`define SCHP_SEL_CTRL1     3'h0
`define SCHP_SEL_CTRL2     3'h2
`define SCHP_SEL_STATUS    3'h4
`define SCHP_SEL_CHARS     3'h4
`define SCHP_SEL_RXHOLD    3'h6
// control register one fields
`define SCHP_C1_TERM_RDY   0
`define SCHP_C1_TX_EN      1
`define SCHP_C1_RX_EN      2
`define SCHP_C1_RX_PAR     3
`define SCHP_C1_ESC_STRIP  4
// control register two fields
`define SCHP_C2_SYNC_MODE  5
`define SCHP_C2_SYNC_STRIP 3
// status fields
`define SCHP_ST_CHANGE     7
`define SCHP_ST_IRQ_ANY    2
// reset values
`define SCHP_CTRL_RST      8'h00
`define SCHP_CHAR_RST      8'h00
`endif

// ===== core/schp_sync2.v
`timescale 1ns/1ns
`default_nettype none
module schp_sync2 #(
    parameter W = 4
) (
    // clock and reset
    input  wire         clk,
    input  wire         reset,
    // async in, synced out
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] meta_ff;
    always @(posedge clk) begin
        if (reset) begin
            meta_ff  <= {W{1'b1}};
            sync_out <= {W{1'b1}};
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule // schp_sync2
`default_nettype wire

// ===== core/schp_edge.v
`timescale 1ns/1ns
`default_nettype none
module schp_edge #(
    parameter W = 4
) (
    // clock and reset
    input  wire         clk,
    input  wire         reset,
    // level in, edges out
    input  wire [W-1:0] level_in,
    output wire [W-1:0] fall,
    output wire [W-1:0] rise,
    output wire [W-1:0] change
);
    reg [W-1:0] prev_ff;
    always @(posedge clk) begin
        if (reset)
            prev_ff <= {W{1'b1}};
        else
            prev_ff <= level_in;
    end
    assign fall   = prev_ff & ~level_in;
    assign rise   = ~prev_ff & level_in;
    assign change = prev_ff ^ level_in;
endmodule // schp_edge
`default_nettype wire

// ===== verif/schp_port_props.sv
`timescale 1ns/1ns
`default_nettype none
module schp_port_props (
    // clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // bus
    input wire logic       shared_addr_data_lines_oe,
    input wire logic       chip_select_n,
    input wire logic       read_strobe_n,
    input wire logic       write_strobe_n,
    input wire logic       bus_acknowledge_n,
    // chain
    input wire logic       ack_chain_in_n,
    input wire logic       ack_chain_out_n,
    input wire logic       irq_request_n,
    // registers
    input wire logic [7:0] tx_holding_reg,
    input wire logic [7:0] control_one_out,
    input wire logic [7:0] control_two_out,
    input wire logic [7:0] sync_char_out,
    input wire logic [7:0] escape_char_out
);
    // ****
    // age of last strobe
    // ****
    logic [3:0] we_age_ff;
    logic [3:0] ia_age_ff;
    always @(posedge clk) begin
        if (reset) begin
            we_age_ff <= 4'hF;
            ia_age_ff <= 4'hF;
        end else begin
            we_age_ff <= !write_strobe_n ? 4'h0 : (we_age_ff == 4'hF ? 4'hF : we_age_ff + 4'h1);
            ia_age_ff <= (!chip_select_n && !ack_chain_in_n) ? 4'h0 : (ia_age_ff == 4'hF ? 4'hF : ia_age_ff + 4'h1);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_idle_no_reply: assert property ((chip_select_n && read_strobe_n)[*8] |-> bus_acknowledge_n)
        else $error("reply while idle");
    a_reply_needs_cs: assert property ($fell(bus_acknowledge_n) |-> !chip_select_n && !$past(chip_select_n, 2))
        else $error("reply without select");
    a_oe_needs_read: assert property (read_strobe_n[*6] |-> !shared_addr_data_lines_oe)
        else $error("lines driven without read");
    a_chain_release: assert property ((chip_select_n && read_strobe_n && ack_chain_in_n)[*6] |-> ack_chain_out_n)
        else $error("chain grant held");
    a_chain_not_pending: assert property ($fell(ack_chain_out_n) |-> $past(irq_request_n))
        else $error("grant passed while pending");
    a_irq_clear_iack: assert property ($rose(irq_request_n) |-> ia_age_ff < 4'h8)
        else $error("request dropped without acknowledge");
    a_tx_needs_write: assert property (!$stable(tx_holding_reg) |-> we_age_ff < 4'h8)
        else $error("holding changed without write");
    a_ctrl_needs_write: assert property (!$stable({control_one_out, control_two_out}) |-> we_age_ff < 4'h8)
        else $error("control changed without write");
    a_escape_after_sync: assert property (!$stable(escape_char_out) |-> $stable(sync_char_out) && we_age_ff < 4'h8)
        else $error("escape and sync changed together");
    c_reply: cover property ($fell(bus_acknowledge_n));
    c_chain: cover property ($fell(ack_chain_out_n));
    c_irq_clear: cover property ($rose(irq_request_n));
endmodule // schp_port_props
bind schp_port schp_port_props i_props (.clk(clk), .reset(reset), .shared_addr_data_lines_oe(shared_addr_data_lines_oe),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .bus_acknowledge_n(bus_acknowledge_n), .ack_chain_in_n(ack_chain_in_n), .ack_chain_out_n(ack_chain_out_n),
    .irq_request_n(irq_request_n), .tx_holding_reg(tx_holding_reg), .control_one_out(control_one_out),
    .control_two_out(control_two_out), .sync_char_out(sync_char_out), .escape_char_out(escape_char_out));
`default_nettype wire

// ===== verif/schp_host.sv
`timescale 1ns/1ns
`default_nettype none
module schp_host (
    // clock
    input wire logic       clk,
    // from device
    input wire logic [7:0] dev_data,
    input wire logic       dev_oe,
    input wire logic       reply_n,
    input wire logic       chain_n,
    // to device
    output var logic [7:0] lines,
    output var logic       cs_n,
    output var logic       re_n,
    output var logic       we_n,
    output var logic       iack_n
);
    initial begin
        lines = 8'hFF;
        cs_n = 1'b1;
        re_n = 1'b1;
        we_n = 1'b1;
        iack_n = 1'b1;
    end
    // ****
    // bus cycle: kind 0 read, 1 write, 2 acknowledge
    // ****
    task automatic cycle(input logic [1:0] kind, input logic [7:0] addr, input logic [7:0] wdata,
                         output logic [7:0] rdata, output logic [1:0] resp);
        int n;
        rdata = 8'h00;
        n = 0;
        @(negedge clk);
        lines = addr;
        repeat (5) @(negedge clk);
        cs_n = 1'b0;
        iack_n = (kind != 2'd2);
        while (reply_n && chain_n && n < 20) begin
            @(negedge clk);
            n++;
        end
        resp = !reply_n ? 2'd1 : (!chain_n ? 2'd2 : 2'd0);
        // lines then carry the write data, or for other kinds the inverse of the last value
        lines = (kind == 2'd1) ? wdata : ~lines;
        repeat (5) @(negedge clk);
        if (resp == 2'd1 && kind == 2'd1) begin
            we_n = 1'b0;
            repeat (6) @(negedge clk);
            we_n = 1'b1;
            repeat (5) @(negedge clk);
            lines = ~lines;
        end else if (resp == 2'd1) begin
            re_n = 1'b0;
            n = 0;
            while (!dev_oe && n < 20) begin
                @(negedge clk);
                n++;
            end
            rdata = dev_data;
            re_n = 1'b1;
            while (dev_oe && n < 40) begin
                @(negedge clk);
                n++;
            end
        end
        cs_n = 1'b1;
        iack_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask
endmodule // schp_host
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam [4:0] TB_ID = 5'h0B; // arbitrary identity value
    logic       clk = 1'b0, reset = 1'b1, dsr_n = 1'b1, cd_n = 1'b1, ring_n = 1'b1;
    logic       rx_load = 1'b0, stop = 1'b1, par = 1'b0, tx_move = 1'b0;
    logic [7:0] rx_char = 8'h00, host_lines, dout, txh, c1, c2, syn, esc, d, v, w, a;
    logic       oe, cs_n, re_n, we_n, ia_n, reply_n, chain_n, irq_n;
    logic [1:0] r;
    int         num_errors = 0, checks_done = 0;
    wire  [7:0] bus = oe ? dout : host_lines;
    always #25 clk = ~clk;
    schp_port #(.DEV_ID(TB_ID)) i_dut (.clk(clk), .reset(reset), .shared_addr_data_lines_in(bus),
        .shared_addr_data_lines_out(dout), .shared_addr_data_lines_oe(oe), .chip_select_n(cs_n),
        .read_strobe_n(re_n), .write_strobe_n(we_n), .bus_acknowledge_n(reply_n), .ack_chain_in_n(ia_n),
        .ack_chain_out_n(chain_n), .irq_request_n(irq_n), .data_set_ready_n(dsr_n), .carrier_detect_n(cd_n),
        .ring_n(ring_n), .rx_load(rx_load), .rx_char(rx_char), .rx_stop_bit(stop), .rx_parity_bad(par),
        .tx_move(tx_move), .tx_holding_reg(txh), .control_one_out(c1), .control_two_out(c2),
        .sync_char_out(syn), .escape_char_out(esc));
    schp_host i_host (.clk(clk), .dev_data(dout), .dev_oe(oe), .reply_n(reply_n), .chain_n(chain_n),
        .lines(host_lines), .cs_n(cs_n), .re_n(re_n), .we_n(we_n), .iack_n(ia_n));
    // ****
    // helpers
    // ****
    function automatic logic [7:0] exp_st(input logic chg, input logic [4:0] low);
        return {chg, ~dsr_n, ~cd_n, low};
    endfunction
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [2:0] sel, output logic [7:0] data);
        logic [1:0] resp;
        i_host.cycle(2'd0, {TB_ID, sel | 3'h1}, 8'h00, data, resp);
    endtask
    task automatic wr(input logic [2:0] sel, input logic [7:0] data);
        logic [7:0] dummy;
        logic [1:0] resp;
        i_host.cycle(2'd1, {TB_ID, sel | 3'h1}, data, dummy, resp);
    endtask
    task automatic st(input logic chg, input logic [4:0] low);
        logic [7:0] got;
        rd(3'h4, got);
        check8("status", exp_st(chg, low), got);
    endtask
    task automatic iack(input logic [1:0] exp_r, input logic [2:0] low);
        i_host.cycle(2'd2, 8'hFE, 8'h00, d, r);
        check8("ack response", {6'h00, exp_r}, {6'h00, r});
        if (exp_r == 2'd1)
            check8("vector", {TB_ID, low}, d);
        check8("irq after ack", 8'h01, {7'h00, irq_n});
        check8("chain after ack", 8'h01, {7'h00, chain_n});
    endtask
    task automatic load_rx(input logic sb, input logic pb, input logic [7:0] ch);
        @(negedge clk);
        rx_char = ch;
        stop = sb;
        par = pb;
        rx_load = 1'b1;
        @(negedge clk);
        rx_load = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        report_and_stop;
    end
    // ****
    // tests
    // ****
    initial begin
        d = $urandom(32'h979C0242);
        repeat (8) @(negedge clk);
        reset = 1'b0;
        repeat (6) @(negedge clk);
        rd(3'h0, d);
        check8("ctrl1 reset", 8'h00, d);
        rd(3'h2, d);
        check8("ctrl2 reset", 8'h00, d);
        st(1'b0, 5'h00);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            v = $urandom & 8'hF8;
            w = $urandom;
            wr(3'h0, v);
            wr(3'h2, w);
            rd(3'h0, d);
            check8("ctrl1", v, d);
            rd(3'h2, d);
            check8("ctrl2", w, d);
            check8("ctrl1 out", v, c1);
            check8("ctrl2 out", w, c2);
        end
        wr(3'h0, 8'h00);
        wr(3'h2, 8'h00);
        i_host.cycle(2'd1, {~TB_ID, 3'h1}, 8'hFF, d, r);
        check8("foreign reply", 8'h00, {6'h00, r});
        check8("ctrl1 kept", 8'h00, c1);
        $display("register test done");
        v = $urandom;
        w = $urandom;
        a = $urandom;
        wr(3'h4, v);
        wr(3'h4, w);
        check8("sync", v, syn);
        check8("escape", w, esc);
        wr(3'h4, ~v);
        rd(3'h0, d);
        wr(3'h4, a);
        check8("sync again", a, syn);
        check8("escape kept", w, esc);
        iack(2'd2, 3'h0);
        $display("char and chain test done");
        wr(3'h0, 8'h04);
        load_rx(1'b1, 1'b0, 8'($urandom));
        check8("irq rx", 8'h00, {7'h00, irq_n});
        iack(2'd1, 3'h4);
        st(1'b0, 5'h02);
        rd(3'h6, d);
        check8("rx holding", rx_char, d);
        st(1'b0, 5'h00);
        wr(3'h0, 8'h0C);
        load_rx(1'b1, 1'b0, 8'($urandom));
        load_rx(1'b0, 1'b1, 8'($urandom));
        st(1'b0, 5'h1E);
        wr(3'h0, 8'h00);
        st(1'b0, 5'h00);
        iack(2'd1, 3'h4);
        $display("receiver test done");
        wr(3'h0, 8'h01);
        dsr_n = 1'b0;
        repeat (8) @(negedge clk);
        st(1'b1, 5'h00);
        st(1'b0, 5'h00);
        check8("irq modem", 8'h00, {7'h00, irq_n});
        iack(2'd1, 3'h4);
        cd_n = 1'b0;
        repeat (8) @(negedge clk);
        st(1'b1, 5'h00);
        {cd_n, dsr_n} = 2'b11;
        repeat (8) @(negedge clk);
        st(1'b1, 5'h00);
        iack(2'd1, 3'h4);
        wr(3'h0, 8'h00);
        dsr_n = 1'b0;
        repeat (8) @(negedge clk);
        st(1'b0, 5'h00);
        dsr_n = 1'b1;
        ring_n = 1'b0;
        repeat (8) @(negedge clk);
        st(1'b1, 5'h00);
        check8("irq ring", 8'h00, {7'h00, irq_n});
        ring_n = 1'b1;
        iack(2'd1, 3'h4);
        $display("modem test done");
        wr(3'h0, 8'h02);
        iack(2'd1, 3'h0);
        st(1'b0, 5'h01);
        v = $urandom;
        wr(3'h6, v);
        check8("tx holding", v, txh);
        st(1'b0, 5'h00);
        @(negedge clk);
        tx_move = 1'b1;
        @(negedge clk);
        tx_move = 1'b0;
        st(1'b0, 5'h01);
        iack(2'd1, 3'h0);
        wr(3'h0, 8'h00);
        st(1'b0, 5'h00);
        $display("transmit test done");
        wr(3'h2, 8'h20);
        wr(3'h0, 8'h04);
        load_rx(1'b1, 1'b0, a);
        st(1'b0, 5'h12);
        load_rx(1'b1, 1'b0, ~a);
        st(1'b0, 5'h06);
        wr(3'h0, 8'h14);
        load_rx(1'b1, 1'b1, w);
        load_rx(1'b1, 1'b1, ~w);
        st(1'b0, {~w == a, 4'hE});
        st(1'b0, {~w == a, 4'h6});
        wr(3'h0, 8'h00);
        st(1'b0, 5'h00);
        $display("sync and escape test done");
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire
